// >>> hw/clk_req_pkg.sv
// Function
// - idle on-demand source stays stopped
// - requests pass through unit to source
// - run while requested, stop when unrequested
// - request needs peripheral, clock, generator enabled
// - clock reaches peripheral after bounded start
// - source stops within bounded delay
// - cleared request_gated_run keeps source running
// - standby requests only with keep_in_standby
// - any reset: 8 MHz RC on, divide by 8
// - power reset: generators 0 and 2 only
// - power reset: only watchdog clock, generator 2
// - user reset keeps locked clocks, watchdog clock if always-on
// - user reset keeps enabled real-time clock
// - 32k sources reset by power reset only
// - generator 0 feeds main_sync_clock
// - each pin is generator input or output
// - pin source code makes pin input
// - write protection, debugger exempt
// - disabled generator output gated off
package clk_req_pkg;
	// register byte offsets
	localparam logic [7:0] CTRL_OFS   = 8'h00;
	localparam logic [7:0] STATUS_OFS = 8'h04;
	localparam logic [7:0] GEN_OFS    = 8'h40;
	localparam logic [7:0] CLK_OFS    = 8'h80;
	localparam logic [7:0] SRC_OFS    = 8'hC0;
	// field positions
	localparam int CTRL_SWRST   = 0;
	localparam int GEN_EN_BIT   = 8;
	localparam int GEN_OE_BIT   = 9;
	localparam int GEN_OOV_BIT  = 10;
	localparam int GEN_KIS_BIT  = 11;
	localparam int CLK_EN_BIT   = 8;
	localparam int CLK_LOCK_BIT = 9;
	localparam int CLK_KIS_BIT  = 10;
	localparam int SRC_EN_BIT   = 0;
	localparam int SRC_OND_BIT  = 1;
	localparam int SRC_KIS_BIT  = 2;
	localparam int SRC_PRE_LSB  = 4;
	// writable bits of each word
	localparam logic [31:0] GEN_WMASK = 32'h0000_0F07;
	localparam logic [31:0] CLK_WMASK = 32'h0000_0707;
	localparam logic [31:0] SRC_WMASK = 32'h0000_0037;
	// source select codes
	localparam logic [2:0] SRC_XOSC    = 3'h0;
	localparam logic [2:0] SRC_PIN     = 3'h1;
	localparam logic [2:0] SRC_GEN1    = 3'h2;
	localparam logic [2:0] SRC_ULP32K  = 3'h3;
	localparam logic [2:0] SRC_OSC32K  = 3'h4;
	localparam logic [2:0] SRC_XOSC32K = 3'h5;
	localparam logic [2:0] SRC_RC8M    = 3'h6;
	localparam logic [2:0] SRC_FLL     = 3'h7;
	// generic clock slots
	localparam int WATCHDOG_ID = 3;
	localparam int RTC_CLK_ID  = 4;
	// values after reset
	localparam logic [31:0] GEN0_RST     = 32'h0000_0106;
	localparam logic [31:0] GEN2_RST     = 32'h0000_0103;
	localparam logic [31:0] WATCHDOG_RST = 32'h0000_0102;
	localparam logic [31:0] RC8M_RST     = 32'h0000_0033;
	localparam logic [31:0] ULP_RST      = 32'h0000_0001;
	localparam logic [31:0] SRC_RST      = 32'h0000_0002;
	localparam logic [31:0] ZERO_RST     = 32'h0000_0000;
	// cycle counts
	localparam logic [1:0] START_CYC = 2'h2;
	localparam logic [1:0] STOP_CYC  = 2'h2;
endpackage

// >>> hw/clk_req_unit.sv
`timescale 1ns/1ns
module clk_req_unit
#(
	parameter int NUM_GEN = 8,
	parameter int NUM_CLK = 8,
	parameter int NUM_SRC = 8
)
(
	// clock and power reset
	input  wire logic                pclk,
	input  wire logic                presetn,
	// apb slave
	input  wire logic                psel,
	input  wire logic                penable,
	input  wire logic                pwrite,
	input  wire logic [7:0]          paddr,
	input  wire logic [31:0]         pwdata,
	output logic      [31:0]         prdata,
	output logic                     pready,
	output logic                     pslverr,
	// system control
	input  wire logic                user_reset,
	input  wire logic                standby,
	input  wire logic                write_protect,
	input  wire logic                debug_access,
	input  wire logic                nvm_watchdog_always_on,
	// peripherals
	input  wire logic [NUM_CLK-1:0]  periph_en,
	input  wire logic [NUM_CLK-1:0]  periph_req,
	output logic      [NUM_CLK-1:0]  periph_clk_gate,
	// clock sources
	input  wire logic [NUM_SRC-1:0]  src_ready,
	output logic      [NUM_SRC-1:0]  src_run,
	output logic      [1:0]          rc8m_presc,
	// generators and pins
	input  wire logic [NUM_GEN-1:0]  gen_clk,
	input  wire logic [NUM_GEN-1:0]  gen_pin_in,
	output logic      [NUM_GEN-1:0]  gen_pin_out,
	output logic      [NUM_GEN-1:0]  gen_pin_oe,
	output logic      [NUM_GEN-1:0]  gen_ext_sel,
	output logic      [NUM_GEN-1:0]  gen_on,
	output logic      [2:0]          main_sync_clock_src,
	output logic                     main_sync_clock_en
);
	import clk_req_pkg::*;

	// configuration words
	logic [31:0]        gen_ff [NUM_GEN];
	logic [31:0]        clk_ff [NUM_CLK];
	logic [31:0]        src_ff [NUM_SRC];
	logic [1:0]         stop_cnt_ff [NUM_SRC];
	logic [1:0]         start_cnt_ff [NUM_CLK];
	logic               swrst_ff;
	logic [NUM_SRC-1:0] src_run_ff;
	logic [NUM_CLK-1:0] gate_ff;
	logic [NUM_GEN-1:0] pin_out_ff;
	logic [NUM_GEN-1:0] pin_oe_ff;
	logic [NUM_GEN-1:0] ext_sel_ff;
	logic [NUM_GEN-1:0] gen_on_ff;
	logic [2:0]         main_src_ff;
	logic               main_en_ff;
	logic [31:0]        prdata_ff;
	logic               pready_ff;
	logic               pslverr_ff;
	logic [31:0]        nxt_prdata;
	logic               nxt_pslverr;
	logic [NUM_CLK-1:0] clk_q;
	logic [NUM_GEN-1:0] gen_req;
	logic [NUM_SRC-1:0] src_req;
	logic [NUM_CLK-1:0] keep_clk;
	logic [NUM_GEN-1:0] keep_gen;
	logic               user_rst;
	logic               wr_ok;
	logic               setup;
	logic               access;

	// reset word of a generator
	function automatic logic [31:0] gen_init(input int g);
		if (g == 0)
			return GEN0_RST;
		else if (g == 2)
			return GEN2_RST;
		return ZERO_RST;
	endfunction

	// reset word of a generic clock
	function automatic logic [31:0] clk_init(input int c);
		if (c == WATCHDOG_ID)
			return WATCHDOG_RST;
		return ZERO_RST;
	endfunction

	// reset word of a clock source
	function automatic logic [31:0] src_init(input int s);
		if (s == int'(SRC_RC8M))
			return RC8M_RST;
		else if (s == int'(SRC_ULP32K))
			return ULP_RST;
		return SRC_RST;
	endfunction

	// 32 kHz sources survive user reset
	function automatic logic is_32k(input int s);
		return s == int'(SRC_ULP32K) || s == int'(SRC_OSC32K) ||
			s == int'(SRC_XOSC32K);
	endfunction

	// bus phases
	assign setup    = psel && !penable;
	assign access   = psel && penable && pready_ff;
	assign wr_ok    = !write_protect || debug_access;
	assign user_rst = user_reset || swrst_ff;

	// request qualification and routing to sources
	always_comb
	begin
		logic [2:0] g;
		logic [2:0] s;
		g = 3'h0;
		s = 3'h0;
		clk_q   = '0;
		gen_req = '0;
		src_req = '0;
		for (int c = 0; c < NUM_CLK; c++)
		begin
			g = clk_ff[c][2:0];
			clk_q[c] = periph_en[c] && periph_req[c] &&
				clk_ff[c][CLK_EN_BIT] && gen_ff[g][GEN_EN_BIT] &&
				(!standby || clk_ff[c][CLK_KIS_BIT]);
			gen_req[g] = gen_req[g] || clk_q[c];
		end
		// pin output and main clock also hold their source
		for (int i = 0; i < NUM_GEN; i++)
			if (gen_ff[i][GEN_OE_BIT] && (!standby || gen_ff[i][GEN_KIS_BIT]))
				gen_req[i] = 1'b1;
		gen_req[0] = 1'b1;
		// generators fed from generator 1 pull it along
		for (int i = 0; i < NUM_GEN; i++)
			if (gen_req[i] && gen_ff[i][GEN_EN_BIT] &&
				gen_ff[i][2:0] == SRC_GEN1)
				gen_req[1] = 1'b1;
		for (int i = 0; i < NUM_GEN; i++)
		begin
			s = gen_ff[i][2:0];
			if (gen_req[i] && gen_ff[i][GEN_EN_BIT])
				src_req[s] = 1'b1;
		end
		for (int j = 0; j < NUM_SRC; j++)
			if (standby && !src_ff[j][SRC_KIS_BIT])
				src_req[j] = 1'b0;
	end

	// which clocks and generators survive a user reset
	always_comb
	begin
		keep_gen = '0;
		for (int c = 0; c < NUM_CLK; c++)
		begin
			keep_clk[c] = clk_ff[c][CLK_LOCK_BIT] ||
				(c == WATCHDOG_ID && nvm_watchdog_always_on) ||
				(c == RTC_CLK_ID && clk_ff[c][CLK_EN_BIT]);
			if (keep_clk[c])
				keep_gen[clk_ff[c][2:0]] = 1'b1;
		end
	end

	// read mux and error decode
	always_comb
	begin
		nxt_prdata  = 32'h0000_0000;
		nxt_pslverr = 1'b0;
		case (paddr[7:5])
			3'h0:
				if (paddr == CTRL_OFS)
					nxt_prdata[CTRL_SWRST] = swrst_ff;
				else if (paddr == STATUS_OFS)
					nxt_prdata[NUM_SRC-1:0] = src_run_ff;
				else
					nxt_pslverr = 1'b1;
			3'h2: nxt_prdata = gen_ff[paddr[4:2]];
			3'h4: nxt_prdata = clk_ff[paddr[4:2]];
			3'h6: nxt_prdata = src_ff[paddr[4:2]];
			default: nxt_pslverr = 1'b1;
		endcase
		if (pwrite)
		begin
			nxt_prdata = 32'h0000_0000;
			if (!wr_ok || paddr == STATUS_OFS)
				nxt_pslverr = 1'b1;
		end
	end

	// apb answer: zero wait states, set up in the setup cycle
	always_ff @(posedge pclk or negedge presetn)
	begin
		if (!presetn)
		begin
			pready_ff  <= 1'b0;
			prdata_ff  <= 32'h0000_0000;
			pslverr_ff <= 1'b0;
		end
		else
		begin
			pready_ff  <= setup;
			prdata_ff  <= setup ? nxt_prdata : 32'h0000_0000;
			pslverr_ff <= setup && nxt_pslverr;
		end
	end

	// software reset strobe, cleared once acted on
	always_ff @(posedge pclk or negedge presetn)
	begin
		if (!presetn)
			swrst_ff <= 1'b0;
		else if (access && pwrite && !pslverr_ff && paddr == CTRL_OFS)
			swrst_ff <= pwdata[CTRL_SWRST];
		else
			swrst_ff <= 1'b0;
	end

	// generator control words
	always_ff @(posedge pclk or negedge presetn)
	begin
		if (!presetn)
			for (int i = 0; i < NUM_GEN; i++)
				gen_ff[i] <= gen_init(i);
		else if (user_rst)
		begin
			for (int i = 0; i < NUM_GEN; i++)
				if (!keep_gen[i])
					gen_ff[i] <= gen_init(i);
		end
		else if (access && pwrite && !pslverr_ff && paddr[7:5] == 3'h2)
			gen_ff[paddr[4:2]] <= pwdata & GEN_WMASK;
	end

	// generic clock control words; locked slots refuse writes
	always_ff @(posedge pclk or negedge presetn)
	begin
		if (!presetn)
			for (int c = 0; c < NUM_CLK; c++)
				clk_ff[c] <= clk_init(c);
		else if (user_rst)
		begin
			for (int c = 0; c < NUM_CLK; c++)
				if (!keep_clk[c])
					clk_ff[c] <= clk_init(c);
		end
		else if (access && pwrite && !pslverr_ff &&
			paddr[7:5] == 3'h4 && !clk_ff[paddr[4:2]][CLK_LOCK_BIT])
			clk_ff[paddr[4:2]] <= pwdata & CLK_WMASK;
	end

	// source control words
	always_ff @(posedge pclk or negedge presetn)
	begin
		if (!presetn)
			for (int j = 0; j < NUM_SRC; j++)
				src_ff[j] <= src_init(j);
		else if (user_rst)
		begin
			for (int j = 0; j < NUM_SRC; j++)
				if (!is_32k(j))
					src_ff[j] <= src_init(j);
		end
		else if (access && pwrite && !pslverr_ff && paddr[7:5] == 3'h6)
			src_ff[paddr[4:2]] <= pwdata & SRC_WMASK;
	end

	// source run control with stop hold-off
	always_ff @(posedge pclk or negedge presetn)
	begin
		if (!presetn)
		begin
			src_run_ff <= '0;
			for (int j = 0; j < NUM_SRC; j++)
				stop_cnt_ff[j] <= 2'h0;
		end
		else
			for (int j = 0; j < NUM_SRC; j++)
				if (!src_ff[j][SRC_EN_BIT])
				begin
					src_run_ff[j]  <= 1'b0;
					stop_cnt_ff[j] <= 2'h0;
				end
				else if (!src_ff[j][SRC_OND_BIT])
					src_run_ff[j] <= 1'b1;
				else if (src_req[j])
				begin
					src_run_ff[j]  <= 1'b1;
					stop_cnt_ff[j] <= STOP_CYC;
				end
				else if (stop_cnt_ff[j] != 2'h0)
					stop_cnt_ff[j] <= stop_cnt_ff[j] - 2'h1;
				else
					src_run_ff[j] <= 1'b0;
	end

	// peripheral clock gate opens after the source is ready
	always_ff @(posedge pclk or negedge presetn)
	begin
		if (!presetn)
		begin
			gate_ff <= '0;
			for (int c = 0; c < NUM_CLK; c++)
				start_cnt_ff[c] <= 2'h0;
		end
		else
			for (int c = 0; c < NUM_CLK; c++)
				if (!(clk_q[c] && src_run_ff[gen_ff[clk_ff[c][2:0]][2:0]] &&
					src_ready[gen_ff[clk_ff[c][2:0]][2:0]]))
				begin
					gate_ff[c]      <= 1'b0;
					start_cnt_ff[c] <= 2'h0;
				end
				else if (start_cnt_ff[c] == START_CYC)
					gate_ff[c] <= 1'b1;
				else
					start_cnt_ff[c] <= start_cnt_ff[c] + 2'h1;
	end

	// generator pins, gating and main clock selection
	always_ff @(posedge pclk or negedge presetn)
	begin
		if (!presetn)
		begin
			pin_out_ff  <= '0;
			pin_oe_ff   <= '0;
			ext_sel_ff  <= '0;
			gen_on_ff   <= '0;
			main_src_ff <= 3'h0;
			main_en_ff  <= 1'b0;
		end
		else
		begin
			for (int i = 0; i < NUM_GEN; i++)
			begin
				ext_sel_ff[i] <= gen_ff[i][2:0] == SRC_PIN;
				gen_on_ff[i]  <= gen_ff[i][GEN_EN_BIT];
				pin_oe_ff[i]  <= gen_ff[i][GEN_EN_BIT] &&
					gen_ff[i][GEN_OE_BIT] && gen_ff[i][2:0] != SRC_PIN;
				if (gen_ff[i][GEN_EN_BIT] && gen_ff[i][GEN_OE_BIT] &&
					(!standby || gen_ff[i][GEN_KIS_BIT]))
					pin_out_ff[i] <= gen_clk[i];
				else
					pin_out_ff[i] <= gen_ff[i][GEN_OOV_BIT];
			end
			main_src_ff <= gen_ff[0][2:0];
			main_en_ff  <= gen_ff[0][GEN_EN_BIT];
		end
	end

	// outputs straight from flip-flops
	assign prdata              = prdata_ff;
	assign pready              = pready_ff;
	assign pslverr             = pslverr_ff;
	assign periph_clk_gate     = gate_ff;
	assign src_run             = src_run_ff;
	assign rc8m_presc          = src_ff[SRC_RC8M][SRC_PRE_LSB+:2];
	assign gen_pin_out         = pin_out_ff;
	assign gen_pin_oe          = pin_oe_ff;
	assign gen_ext_sel         = ext_sel_ff;
	assign gen_on              = gen_on_ff;
	assign main_sync_clock_src = main_src_ff;
	assign main_sync_clock_en  = main_en_ff;

	// checks on the rc8m and osc32k sources, clocks 0 and 6, generators 0 and 3
	default clocking cb @(posedge pclk); endclocking
	default disable iff (!presetn);

	AST_IDLE_STOPS: assert property (
		(src_ff[6][0] && src_ff[6][1] && !src_req[6] && !user_rst) [*3]
		|=> !src_run_ff[6])
		else $error("idle on-demand source still running");
	AST_REQ_RUNS: assert property (
		presetn && src_ff[6][0] && src_req[6] && !user_rst
		|=> src_run_ff[6])
		else $error("requested source not running");
	AST_NO_OND: assert property (
		presetn && src_ff[6][0] && !src_ff[6][1] && !user_rst
		|=> src_run_ff[6])
		else $error("free-running source stopped");
	AST_GATE_QUAL: assert property (
		gate_ff[0] |-> $past(clk_q[0]))
		else $error("gate open without qualified request");
	AST_START_MIN: assert property (
		$rose(gate_ff[0]) |-> $past(clk_q[0], 3) && $past(clk_q[0], 2))
		else $error("clock delivered too early");
	AST_STANDBY: assert property (
		standby && !clk_ff[0][CLK_KIS_BIT] |=> !gate_ff[0])
		else $error("request active in standby");
	AST_PIN_IN: assert property (
		gen_ff[3][2:0] == SRC_PIN |=> ext_sel_ff[3] && !pin_oe_ff[3])
		else $error("pin source not an input");
	AST_GEN_OFF: assert property (
		!gen_ff[3][GEN_EN_BIT] |=> !gen_on_ff[3] && !pin_oe_ff[3])
		else $error("disabled generator not gated");
	AST_MAIN: assert property (
		presetn |=> main_src_ff == $past(gen_ff[0][2:0]))
		else $error("main clock not from generator 0");
	AST_PROT: assert property (
		setup && pwrite && write_protect && !debug_access |=> pslverr_ff)
		else $error("protected write not refused");
	AST_LOCK: assert property (
		user_rst && clk_ff[6][CLK_LOCK_BIT] |=> $stable(clk_ff[6]))
		else $error("locked clock lost on user reset");
	AST_32K: assert property (
		user_rst |=> $stable(src_ff[4]))
		else $error("32k source reset by user reset");

	COV_START: cover property ($rose(gate_ff[0]));
	COV_STOP: cover property ($fell(src_run_ff[6]));
	COV_URST: cover property (user_rst && clk_ff[6][CLK_LOCK_BIT]);
endmodule // clk_req_unit

// >>> dv/periph_model.sv
`timescale 1ns/1ns
// peripheral side: enables and requests as registered levels
module periph_model
(
	// clock and reset
	input  wire logic       pclk,
	input  wire logic       presetn,
	// wishes from the bench
	input  wire logic [7:0] want_en,
	input  wire logic [7:0] want_req,
	// towards the unit
	output logic      [7:0] periph_en,
	output logic      [7:0] periph_req
);
	// levels change only just after an edge
	always_ff @(posedge pclk or negedge presetn)
	begin
		if (!presetn)
		begin
			periph_en  <= 8'h00;
			periph_req <= 8'h00;
		end
		else
		begin
			periph_en  <= want_en;
			periph_req <= want_req;
		end
	end
endmodule // periph_model

// >>> dv/on_demand_clock_request_and_reset_test.sv
`timescale 1ns/1ns
module on_demand_clock_request_and_reset_test;
	import clk_req_pkg::*;
	// power reset images: addresses and values
	localparam logic [7:0]  RADR [8] = '{8'h40, 8'h44, 8'h48, 8'h80,
		8'h8C, 8'hC0, 8'hCC, 8'hD8};
	localparam logic [31:0] RVAL [8] = '{GEN0_RST, ZERO_RST, GEN2_RST,
		ZERO_RST, WATCHDOG_RST, SRC_RST, ULP_RST, RC8M_RST};
	// user reset images
	localparam logic [7:0]  UADR [6] = '{8'h8C, 8'h90, 8'h94, 8'h98,
		8'hC0, 8'hD0};
	localparam logic [31:0] UVAL [6] = '{32'h0000_0101, 32'h0000_0102,
		32'h0000_0000, 32'h0000_0301, 32'h0000_0002, 32'h0000_0003};
	logic        pclk, presetn, psel, penable, pwrite, pready, pslverr;
	logic [7:0]  paddr;
	logic [31:0] pwdata, prdata, rd;
	logic        user_reset, standby, write_protect, debug_access, nvm_on;
	logic [7:0]  want_en, want_req, periph_en, periph_req, gate;
	logic [7:0]  src_ready, src_run, gen_clk, ext_sel, pin_oe, gen_on, pout;
	logic [1:0]  presc;
	logic [2:0]  main_src;
	logic        main_en, er;
	int          n_fail, n_tests, n;

	clk_req_unit clk_req_unit_inst (.pclk(pclk), .presetn(presetn),
		.psel(psel), .penable(penable), .pwrite(pwrite), .paddr(paddr),
		.pwdata(pwdata), .prdata(prdata), .pready(pready),
		.pslverr(pslverr), .user_reset(user_reset), .standby(standby),
		.write_protect(write_protect), .debug_access(debug_access),
		.nvm_watchdog_always_on(nvm_on), .periph_en(periph_en),
		.periph_req(periph_req), .periph_clk_gate(gate),
		.src_ready(src_ready), .src_run(src_run), .rc8m_presc(presc),
		.gen_clk(gen_clk), .gen_pin_in(8'h00), .gen_pin_out(pout),
		.gen_pin_oe(pin_oe), .gen_ext_sel(ext_sel), .gen_on(gen_on),
		.main_sync_clock_src(main_src), .main_sync_clock_en(main_en));

	periph_model periph_model_inst (.pclk(pclk), .presetn(presetn),
		.want_en(want_en), .want_req(want_req), .periph_en(periph_en),
		.periph_req(periph_req));

	// bus clock
	initial
	begin
		pclk = 1'b0;
		forever #4 pclk = ~pclk;
	end

	// sources become ready a cycle after run; generator outputs toggle
	always @(posedge pclk)
	begin
		src_ready <= src_run;
		gen_clk   <= ~gen_clk;
	end

	// compare and count
	task check(input logic [31:0] seen, input logic [31:0] exp);
		n_tests++;
		if (seen !== exp)
		begin
			n_fail++;
			$display("unexpected at %0t: seen %h expected %h", $time, seen,
				exp);
		end
	endtask

	// one bus transfer, held until pready
	task apb(input logic w, input logic [7:0] a, input logic [31:0] d);
		psel   <= 1'b1;
		pwrite <= w;
		paddr  <= a;
		pwdata <= d;
		@(posedge pclk);
		penable <= 1'b1;
		do
			@(posedge pclk);
		while (pready !== 1'b1);
		rd = prdata;
		er = pslverr;
		psel    <= 1'b0;
		penable <= 1'b0;
		@(posedge pclk);
	endtask

	task wr(input logic [7:0] a, input logic [31:0] d, input logic e);
		apb(1'b1, a, d);
		check(er, e);
	endtask

	task rdc(input logic [7:0] a, input logic [31:0] exp, input logic e);
		apb(1'b0, a, 32'h0);
		check(rd, exp);
		check(er, e);
	endtask

	task cyc(input int k);
		repeat (k) @(posedge pclk);
	endtask

	// bounded wait for source run (0) or gate (1) of slot 0
	task wait_for(input int sel, input logic v, input int lo, input int hi);
		n = 0;
		while ((sel != 0 ? gate[0] : src_run[0]) !== v && n < 40)
		begin
			@(posedge pclk);
			n++;
		end
		check(n >= lo && n <= hi, 1'b1);
	endtask

	task results;
		$display("mismatches %0d, checks %0d", n_fail, n_tests);
		if (n_fail == 0 && n_tests > 0)
			$display("All tests passed");
		else
			$display("Some tests failed");
		$finish;
	endtask

	// watchdog
	initial
	begin
		#100000;
		n_fail++;
		results;
	end

	// main sequence
	initial
	begin
		{psel, penable, pwrite, paddr, pwdata} = '0;
		{user_reset, standby, write_protect, debug_access, nvm_on} = '0;
		{want_en, want_req, gen_clk, src_ready} = '0;
		n_fail = 0;
		n_tests = 0;
		presetn = 1'b0;
		cyc(20);
		presetn <= 1'b1;
		cyc(3);
		check(gen_on, 8'h05);
		check(main_src, SRC_RC8M);
		check({main_en, presc}, 3'h7);
		foreach (RADR[i]) rdc(RADR[i], RVAL[i], 1'b0);
		// refused transfers and protection
		rdc(8'h20, 32'h0, 1'b1);
		wr(8'h04, 32'hFF, 1'b1);
		write_protect <= 1'b1;
		wr(8'h44, 32'h100, 1'b1);
		rdc(8'h44, 32'h0, 1'b0);
		debug_access <= 1'b1;
		wr(8'h44, 32'h100, 1'b0);
		write_protect <= 1'b0;
		debug_access <= 1'b0;
		// source 0 on demand behind generator 1 and clock 0
		wr(8'hC0, 32'h3, 1'b0);
		wr(8'h80, 32'h101, 1'b0);
		cyc(4);
		check(src_run[0], 1'b0);
		want_req <= 8'h01;
		cyc(8);
		check(src_run[0], 1'b0);
		want_en <= 8'h01;
		wait_for(0, 1'b1, 1, 4);
		wait_for(1, 1'b1, 2, 6);
		want_req <= 8'h00;
		wait_for(1, 1'b0, 1, 3);
		wait_for(0, 1'b0, 1, 5);
		// standby needs keep bits
		standby <= 1'b1;
		want_req <= 8'h01;
		cyc(8);
		check(src_run[0], 1'b0);
		wr(8'h80, 32'h501, 1'b0);
		wr(8'hC0, 32'h7, 1'b0);
		wait_for(0, 1'b1, 0, 6);
		standby <= 1'b0;
		want_req <= 8'h00;
		// on-demand off: runs without request
		wr(8'hC0, 32'h1, 1'b0);
		cyc(8);
		check(src_run[0], 1'b1);
		rdc(8'h04, 32'h49, 1'b0);
		// pins: generator 3 from pin, generator 4 driving out
		wr(8'h4C, 32'h301, 1'b0);
		wr(8'h50, 32'h306, 1'b0);
		wr(8'h54, 32'h406, 1'b0);
		cyc(2);
		check(ext_sel[4:3], 2'b01);
		check(pin_oe[4:3], 2'b10);
		check(pout[5], 1'b1);
		rd[0] = pout[4];
		cyc(1);
		check(pout[4], !rd[0]);
		wr(8'h48, 32'h003, 1'b0);
		cyc(2);
		check(gen_on[2], 1'b0);
		// user reset keeps locked, always-on, timer and 32k parts
		nvm_on <= 1'b1;
		wr(8'h8C, 32'h101, 1'b0);
		wr(8'h90, 32'h102, 1'b0);
		wr(8'h94, 32'h101, 1'b0);
		wr(8'h98, 32'h301, 1'b0);
		wr(8'hD0, 32'h3, 1'b0);
		user_reset <= 1'b1;
		cyc(1);
		user_reset <= 1'b0;
		cyc(1);
		foreach (UADR[i]) rdc(UADR[i], UVAL[i], 1'b0);
		rdc(8'h4C, 32'h0, 1'b0);
		check({main_en, presc}, 3'h7);
		// software reset through the control word
		wr(8'h94, 32'h101, 1'b0);
		wr(8'h00, 32'h1, 1'b0);
		rdc(8'h94, 32'h0, 1'b0);
		rdc(8'h98, 32'h301, 1'b0);
		rdc(8'h00, 32'h0, 1'b0);
		results;
	end
endmodule // on_demand_clock_request_and_reset_test
